// ### pkg/timer_base_pkg.sv
package timer_base_pkg;

	// ==========================================================
	// Register indices on the plain register port
	localparam logic [2:0] reg_status_control = 3'h0;
	localparam logic [2:0] reg_count_high = 3'h1;
	localparam logic [2:0] reg_count_low = 3'h2;
	localparam logic [2:0] reg_modulo_high = 3'h3;
	localparam logic [2:0] reg_modulo_low = 3'h4;
	localparam logic [2:0] reg_system_option = 3'h5;

	// ==========================================================
	// Status/control and system option field positions
	localparam int overflow_flag_bit = 7;
	localparam int overflow_irq_enable_bit = 6;
	localparam int center_align_select_bit = 5;
	localparam int clock_source_hi = 4;
	localparam int clock_source_lo = 3;
	localparam int prescale_hi = 2;
	localparam int prescale_lo = 0;
	localparam int slow_osc_route_bit = 0;

	// ==========================================================
	// Reset values and the full-range modulo top
	localparam logic [7:0] status_control_reset = 8'h00;
	localparam logic [15:0] count_reset = 16'h0000;
	localparam logic [15:0] modulo_reset = 16'h0000;
	localparam logic [15:0] modulo_all_ones = 16'hffff;

	// Clock source codes
	localparam logic [1:0] clock_source_none = 2'h0;
	localparam logic [1:0] clock_source_bus = 2'h1;
	localparam logic [1:0] clock_source_unused = 2'h2;
	localparam logic [1:0] clock_source_crystal = 2'h3;

	// Widest prescaler divide is 2**7 = 128
	localparam int prescale_width = 7;

endpackage

// ### hdl/timer_pwm_counter_base.sv
// How it works
// - Clock source field picks none, bus, or crystal
// - Prescaler divides by two to the field
// - Prescaler follows source sync and selection
// - Crystal clock synchronised before it counts
// - Sixteen-bit counter, up or up/down
// - Modulo zero or all ones runs free
// - Any counter byte write clears counter
// - Counter reads never disturb counting
// - Up mode flags overflow on wrap
// - Center mode flags overflow stepping down
// - Clear flag by read-then-write zero
// - New overflow restarts the clear sequence
// - Interrupt requested while flag and enable
// - Center select forces up/down for channels
// - Reset clears flag, enable, center select
// - Byte read latches both counter bytes
// - Latch restarts on reset or counter or status writes
// - Debug halt freezes counter and latch
// - Reset clears the counter
// - After reset unit disabled, pins follow port
// - Timer owned pin ignores port settings
// - Option bit routes channel zero input
// - Modulo byte write suppresses overflow
module timer_pwm_counter_base
	import timer_base_pkg::*;
#(
	parameter int count_width = 16,
	parameter int prescale_steps = 8
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic crystal_derived_clock,
	input wire logic debug_halt_state,
	input wire logic channel_pin_in,
	input wire logic low_freq_oscillator,
	input wire logic port_data,
	input wire logic port_direction,
	input wire logic channel_owns_pin,
	input wire logic channel_pin_drive,
	output logic channel_zero_in,
	output logic pin_out,
	output logic pin_oe,
	output logic pin_pullup_en,
	output logic timer_enabled,
	output logic [15:0] count_value,
	output logic count_down,
	output logic center_aligned_pwm,
	output logic overflow_irq
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] rdata;
		logic overflow_flag;
		logic overflow_irq_enable;
		logic center_align_select;
		logic [1:0] clock_source_select;
		logic [2:0] prescale_select;
		logic [15:0] count;
		logic down;
		logic [15:0] modulo;
		logic [7:0] modulo_high_hold;
		logic modulo_pending;
		logic [15:0] latch;
		logic latched;
		logic clear_armed;
		logic [prescale_width-1:0] prescale;
		logic xtal_s1;
		logic xtal_s2;
		logic xtal_s3;
		logic chan_s1;
		logic chan_s2;
		logic lfo_s1;
		logic lfo_s2;
		logic halt_s1;
		logic halt_s2;
		logic slow_osc_route_select;
	} state_s;

	state_s q, d;

	logic source_tick;
	logic prescale_tick;
	logic [15:0] top;
	logic overflow_event;
	logic count_write;
	logic [7:0] status_view;
	logic at_top;
	logic at_floor;
	logic [15:0] count_up;
	logic [15:0] count_dn;
	logic pin_owned;

	// ==========================================================
	// Elaboration checks
	// The byte-wide register map only covers a sixteen-bit counter
	if (count_width != 16) begin : g_bad_count_width
		$error("count_width must be 16");
	end
	// Eight divisors need a seven-bit ripple count, no more and no less
	if (prescale_steps != prescale_width + 1) begin : g_bad_prescale
		$error("prescale_steps must match the prescaler width");
	end

	// ==========================================================
	// Clocking and counting
	always_comb begin
		d = q;
		d.xtal_s1 = crystal_derived_clock;
		d.xtal_s2 = q.xtal_s1;
		d.xtal_s3 = q.xtal_s2;
		d.chan_s1 = channel_pin_in;
		d.chan_s2 = q.chan_s1;
		d.lfo_s1 = low_freq_oscillator;
		d.lfo_s2 = q.lfo_s1;
		d.halt_s1 = debug_halt_state;
		d.halt_s2 = q.halt_s1;

		// Crystal clock counts on its synchronised rising edge
		unique case (q.clock_source_select)
			clock_source_bus: source_tick = 1'b1;
			clock_source_crystal: source_tick = q.xtal_s2 & ~q.xtal_s3;
			default: source_tick = 1'b0;
		endcase

		// Prescaler sits after the source mux, so it divides either source
		prescale_tick = 1'b0;
		if (!q.halt_s2 && source_tick) begin
			d.prescale = q.prescale + 1'b1;
			unique case (q.prescale_select)
				3'h0: prescale_tick = 1'b1;
				3'h1: prescale_tick = &q.prescale[0:0];
				3'h2: prescale_tick = &q.prescale[1:0];
				3'h3: prescale_tick = &q.prescale[2:0];
				3'h4: prescale_tick = &q.prescale[3:0];
				3'h5: prescale_tick = &q.prescale[4:0];
				3'h6: prescale_tick = &q.prescale[5:0];
				3'h7: prescale_tick = &q.prescale[6:0];
			endcase
		end

		// Modulo 0 or ffff both mean the full range
		top = (q.modulo == modulo_reset) ? modulo_all_ones : q.modulo;

		// A count above the top (modulo lowered while running) wraps in up mode, or turns down in center mode, at once
		// rather than running the whole sixteen-bit range first
		at_top = (q.count >= top);
		at_floor = (q.count <= 16'h0001);
		count_up = q.count + 16'h0001;
		count_dn = q.count - 16'h0001;

		overflow_event = 1'b0;
		if (prescale_tick) begin
			if (!q.center_align_select) begin
				d.down = 1'b0;
				if (at_top) begin
					d.count = count_reset;
					overflow_event = 1'b1;
				end else begin
					d.count = count_up;
				end
			end else if (q.down) begin
				// Turning point at the bottom carries no flag
				if (at_floor) begin
					d.count = count_reset;
					d.down = 1'b0;
				end else begin
					d.count = count_dn;
				end
			end else if (at_top) begin
				// Flag goes with the first step down, not with reaching the top
				d.count = count_dn;
				d.down = 1'b1;
				overflow_event = 1'b1;
			end else begin
				d.count = count_up;
			end
		end
		// Modulo half-written: hold off the flag
		if (q.modulo_pending) begin
			overflow_event = 1'b0;
		end

		// ======================================================
		// Register port
		count_write = reg_write &&
			(reg_addr == reg_count_high || reg_addr == reg_count_low);
		status_view = {q.overflow_flag, q.overflow_irq_enable, q.center_align_select,
			q.clock_source_select, q.prescale_select};

		if (count_write) begin
			d.count = count_reset;
			d.down = 1'b0;
			d.prescale = '0;
			d.latched = 1'b0;
		end

		d.rdata = 8'h00;
		if (reg_read) begin
			unique case (reg_addr)
				reg_status_control: begin
					d.rdata = status_view;
					if (q.overflow_flag) begin
						d.clear_armed = 1'b1;
					end
				end
				reg_count_high, reg_count_low: begin
					// Second byte comes from the latch so the pair is coherent
					if (q.latched) begin
						if (reg_addr == reg_count_high) begin
							d.rdata = q.latch[15:8];
						end else begin
							d.rdata = q.latch[7:0];
						end
						if (!q.halt_s2) begin
							d.latched = 1'b0;
						end
					end else begin
						if (reg_addr == reg_count_high) begin
							d.rdata = q.count[15:8];
						end else begin
							d.rdata = q.count[7:0];
						end
						if (!q.halt_s2) begin
							d.latch = q.count;
							d.latched = 1'b1;
						end
					end
				end
				reg_modulo_high: d.rdata = q.modulo[15:8];
				reg_modulo_low: d.rdata = q.modulo[7:0];
				reg_system_option: d.rdata = {7'h00, q.slow_osc_route_select};
				default: d.rdata = 8'h00;
			endcase
		end

		if (reg_write) begin
			unique case (reg_addr)
				reg_status_control: begin
					d.overflow_irq_enable = reg_wdata[overflow_irq_enable_bit];
					d.center_align_select = reg_wdata[center_align_select_bit];
					d.clock_source_select = reg_wdata[clock_source_hi:clock_source_lo];
					d.prescale_select = reg_wdata[prescale_hi:prescale_lo];
					d.latched = 1'b0;
					if (q.clear_armed && !reg_wdata[overflow_flag_bit]) begin
						d.overflow_flag = 1'b0;
					end
					d.clear_armed = 1'b0;
				end
				reg_modulo_high: begin
					d.modulo_high_hold = reg_wdata;
					d.modulo_pending = ~q.modulo_pending;
					if (q.modulo_pending) begin
						d.modulo = {reg_wdata, q.modulo[7:0]};
					end
				end
				reg_modulo_low: begin
					d.modulo_pending = ~q.modulo_pending;
					d.modulo = {q.modulo_pending ? q.modulo_high_hold : q.modulo[15:8], reg_wdata};
				end
				reg_system_option: d.slow_osc_route_select = reg_wdata[slow_osc_route_bit];
				default: ;
			endcase
		end

		// Set beats clear; a fresh overflow also disarms a pending clear
		if (overflow_event) begin
			d.overflow_flag = 1'b1;
			d.clear_armed = 1'b0;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata = q.rdata;
	assign overflow_irq = q.overflow_flag & q.overflow_irq_enable;
	assign timer_enabled = (q.clock_source_select != clock_source_none);
	assign count_value = q.count;
	assign count_down = q.down;
	assign center_aligned_pwm = q.center_align_select;
	// Both candidates are already synchronised, so switching the route
	// can at worst cut one pulse short; it never shows a metastable level
	assign channel_zero_in = q.slow_osc_route_select ? q.lfo_s2 : q.chan_s2;

	// ==========================================================
	// Pin sharing
	// While the timer owns the pin the port bits are ignored outright,
	// so software cannot disturb a running waveform through the port
	assign pin_owned = timer_enabled && channel_owns_pin;
	always_comb begin
		if (pin_owned) begin
			pin_out = channel_pin_drive;
			pin_oe = 1'b1;
		end else begin
			pin_out = port_data;
			pin_oe = port_direction;
		end
	end

	// No pullup control is kept here; after reset the pin direction follows port_direction
	assign pin_pullup_en = 1'b0;

endmodule

// ### test/timer_base_props.sv
module timer_base_props
	import timer_base_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic timer_enabled,
	input wire logic [15:0] count_value,
	input wire logic center_aligned_pwm,
	input wire logic overflow_irq,
	input wire logic pin_pullup_en
);
	logic [6:0] ctl_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// Shadow of the control bits, so no internal probes are needed
	always_ff @(posedge clk_sys)
		if (!reset_n)
			ctl_q <= '0;
		else if (reg_write && reg_addr == reg_status_control)
			ctl_q <= reg_wdata[6:0];
	sequence cnt_wr;
		reg_write && (reg_addr == reg_count_high || reg_addr == reg_count_low);
	endsequence
	// ==========================================================
	chk_src_enable: assert property (timer_enabled == (ctl_q[4:3] != 2'h0))
		else $error("enable does not follow source");
	chk_cnt_clear: assert property (cnt_wr |=> count_value == 16'h0000)
		else $error("count write did not clear");
	chk_idle_hold: assert property (!timer_enabled && !reg_write |=> $stable(count_value))
		else $error("count moved with no source");
	chk_up_step: assert property (ctl_q[5:0] == 6'h08 && !reg_write
		|=> count_value == $past(count_value) + 16'h0001 || count_value == 16'h0000)
		else $error("count did not step by one");
	chk_irq_mask: assert property (!ctl_q[6] |-> !overflow_irq)
		else $error("interrupt while disabled");
	chk_center_sel: assert property (center_aligned_pwm == ctl_q[5])
		else $error("center mode does not follow select");
	chk_pullup_off: assert property (!pin_pullup_en)
		else $error("pullup enabled");
	chk_reset_vals: assert property (disable iff (1'b0) !reset_n |=>
		count_value == 16'h0000 && !overflow_irq && !timer_enabled && !center_aligned_pwm)
		else $error("reset state wrong");
endmodule

bind timer_pwm_counter_base timer_base_props u_props(.clk_sys(clk_sys), .reset_n(reset_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.timer_enabled(timer_enabled), .count_value(count_value),
	.center_aligned_pwm(center_aligned_pwm), .overflow_irq(overflow_irq),
	.pin_pullup_en(pin_pullup_en));

// ### test/timer_pwm_counter_base_tb.sv
module timer_pwm_counter_base_tb import timer_base_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
	logic crystal_derived_clock = 1'b0, debug_halt_state = 1'b0;
	logic channel_pin_in = 1'b0, low_freq_oscillator = 1'b0, port_data = 1'b0;
	logic port_direction = 1'b0, channel_owns_pin = 1'b0, channel_pin_drive = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
	logic [15:0] count_value, v, s;
	logic count_down, overflow_irq, pin_pullup_en, en, cz, po, poe;
	logic [7:0] ctl = 8'h00;
	logic rt = 1'b0;
	logic [1:0] hl = 2'h0, hc = 2'h0;
	int failures = 0, cmp_count = 0, cyc = 0, m;

	timer_pwm_counter_base u_dut(.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .crystal_derived_clock, .debug_halt_state, .channel_pin_in,
		.low_freq_oscillator, .port_data, .port_direction, .channel_owns_pin,
		.channel_pin_drive, .channel_zero_in(cz), .pin_out(po), .pin_oe(poe), .pin_pullup_en,
		.timer_enabled(en), .count_value, .count_down, .center_aligned_pwm(), .overflow_irq);

	// ==========================================================
	initial forever #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		{port_data, port_direction, channel_owns_pin, channel_pin_drive} <= 4'($urandom);
		{channel_pin_in, low_freq_oscillator} <= 2'($urandom);
		hl <= {hl[0], low_freq_oscillator};
		hc <= {hc[0], channel_pin_in};
		cyc++;
		if (cyc == 20000) begin
			failures++;
			summarize();
		end
	end

	// Pin sharing and routing, against the bench's own copy of the registers
	always @(negedge clk_sys) begin
		if (reset_n && cyc > 12) begin
			check("enabled", 16'(en), 16'(ctl[4:3] != 2'h0));
			check("pin oe", 16'(poe), 16'(ctl[4:3] != 2'h0 && channel_owns_pin ? 1'b1 : port_direction));
			check("pin out", 16'(po), 16'(ctl[4:3] != 2'h0 && channel_owns_pin ? channel_pin_drive : port_data));
			check("chan zero", 16'(cz), 16'(rt ? hl[1] : hc[1]));
			check("pullup", 16'(pin_pullup_en), 16'h0000);
		end
	end

	task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// Both tasks start and end just after a rising edge
	task automatic wr(logic [2:0] a, logic [7:0] w);
		reg_addr <= a;
		reg_wdata <= w;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		if (a == reg_status_control)
			ctl = w;
		if (a == reg_system_option)
			rt = w[0];
		reg_write <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(logic [2:0] a);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(negedge clk_sys);
		s = count_value;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
		@(posedge clk_sys);
	endtask
	task automatic settle(int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================================
	initial begin
		void'($urandom(93464));
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		rd(reg_status_control);
		check("status", 16'(d), 16'h0000);
		rd(reg_count_low);
		check("count", 16'(d), 16'h0000);
		rd(reg_count_high);
		check("count high", 16'(d), 16'h0000);
		rd(3'h7);
		check("unmapped", 16'(d), 16'h0000);
		wr(reg_status_control, 8'h08);
		repeat ($urandom % 40) @(posedge clk_sys);
		rd(reg_count_high);
		v = s;
		check("count high", 16'(d), 16'(v[15:8]));
		repeat (300) @(posedge clk_sys);
		rd(reg_count_low);
		check("latched low", 16'(d), 16'(v[7:0]));
		$display("coherent read test done");
		for (int p = 0; p < 8; p++) begin
			wr(reg_status_control, {5'h01, 3'(p)});
			wr(reg_count_low, 8'($urandom));
			v = count_value;
			for (int w = 0; w < 300 && count_value === v; w++) @(negedge clk_sys);
			v = count_value;
			settle(4 << p);
			check("prescale", count_value, v + 16'h0004);
			@(posedge clk_sys);
		end
		wr(reg_status_control, 8'h18);
		wr(reg_count_low, 8'h00);
		repeat (6) begin
			crystal_derived_clock <= 1'b1;
			repeat (3) @(posedge clk_sys);
			crystal_derived_clock <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
		settle(5);
		check("crystal", count_value, 16'h0006);
		@(posedge clk_sys);
		$display("clock source test done");
		m = 4 + $urandom % 12;
		wr(reg_modulo_high, 8'h00);
		wr(reg_modulo_low, 8'(m));
		wr(reg_count_low, 8'h00);
		wr(reg_status_control, 8'h48);
		for (int w = 0; w < 40 && overflow_irq !== 1'b1; w++) @(negedge clk_sys);
		check("wrap", count_value, 16'h0000);
		@(posedge clk_sys);
		wr(reg_status_control, 8'h40);
		check("irq", 16'(overflow_irq), 16'h0001);
		rd(reg_status_control);
		wr(reg_status_control, 8'hc0);
		check("irq", 16'(overflow_irq), 16'h0001);
		rd(reg_status_control);
		check("flag", 16'(d[7]), 16'h0001);
		wr(reg_status_control, 8'h40);
		check("irq", 16'(overflow_irq), 16'h0000);
		wr(reg_count_low, 8'h00);
		wr(reg_status_control, 8'h68);
		for (int w = 0; w < 40 && count_value !== 16'(m); w++) @(negedge clk_sys);
		check("irq", 16'(overflow_irq), 16'h0000);
		settle(1);
		check("down count", count_value, 16'(m - 1));
		check("down dir", 16'(count_down), 16'h0001);
		check("down irq", 16'(overflow_irq), 16'h0001);
		@(posedge clk_sys);
		$display("overflow test done");
		wr(reg_status_control, 8'h09);
		debug_halt_state <= 1'b1;
		settle(4);
		v = count_value;
		settle(20);
		check("halt", count_value, v);
		@(posedge clk_sys);
		debug_halt_state <= 1'b0;
		$display("halt test done");
		wr(reg_system_option, 8'h01);
		repeat (20) @(posedge clk_sys);
		rd(reg_system_option);
		check("route", 16'(d), 16'h0001);
		$display("route test done");
		summarize();
	end
endmodule
